// ==== logic/conv_mode_pkg.sv ====
// Constants and types for the converter mode-control block
package conv_mode_pkg;
    // ------------------------------------------------------------
    // Register layout
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_CTRL_RESET  = 8'h00;  // Power-on value
    localparam int         PRIMARY_EN_BIT   = 5;      // Primary enable position
    localparam int         AUX_EN_BIT       = 4;      // Auxiliary enable position
    localparam int         MODE_MSB         = 2;      // Mode field top bit
    localparam int         MODE_LSB         = 0;      // Mode field bottom bit
    localparam logic [7:0] MODE_CTRL_WMASK  = 8'h37;  // Writable bits
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int         RESET_PULSE_CYC  = 1;      // Length of converter reset pulse

    // Mode codes of the shared field
    typedef enum logic [2:0] {
        MODE_POWER_DOWN = 3'h0,
        MODE_IDLE       = 3'h1,
        MODE_SINGLE     = 3'h2,
        MODE_CONTINUOUS = 3'h3,
        MODE_INT_ZERO   = 3'h4,
        MODE_INT_FULL   = 3'h5,
        MODE_SYS_ZERO   = 3'h6,
        MODE_SYS_FULL   = 3'h7
    } conv_mode_t;

    // Analog input routing selection per converter
    typedef enum logic [1:0] {
        ROUTE_CHANNEL   = 2'h0,
        ROUTE_SHORT     = 2'h1,
        ROUTE_REFERENCE = 2'h2
    } input_route_t;
endpackage

// ==== logic/adc_mode_control.sv ====
// Mode sequencing for the primary and auxiliary sigma-delta converters
`timescale 1ns/1ps
`default_nettype none
module adc_mode_control
(
    // Clock and reset
    input  wire logic                    CLK,
    input  wire logic                    RESETN,
    // Register port of the mode-control register
    input  wire logic                    MODE_WR,        // One-cycle write strobe
    input  wire logic [7:0]              MODE_WDATA,
    output var  logic [7:0]              MODE_RDATA,
    // Writes of the per-converter control registers
    input  wire logic                    PRIMARY_CTRL_WR,
    input  wire logic                    AUX_CTRL_WR,
    input  wire logic                    PRIMARY_REF_SEL,  // 1: external reference
    input  wire logic                    AUX_REF_SEL,
    // Events from the filters, same clock
    input  wire logic                    PRIMARY_DONE,     // Output word ready
    input  wire logic                    AUX_DONE,
    // Converter controls
    output var  logic                    PRIMARY_POWER,
    output var  logic                    AUX_POWER,
    output var  logic                    PRIMARY_HOLD_RESET,
    output var  logic                    AUX_HOLD_RESET,
    output var  logic                    PRIMARY_CLK_EN,
    output var  logic                    AUX_CLK_EN,
    output var  logic                    PRIMARY_RESTART,  // One-cycle converter reset
    output var  logic                    AUX_RESTART,
    output var  conv_mode_pkg::input_route_t PRIMARY_ROUTE,
    output var  conv_mode_pkg::input_route_t AUX_ROUTE,
    output var  logic                    PRIMARY_REF_EXT,
    output var  logic                    AUX_REF_EXT,
    output var  logic                    CAL_ACTIVE,
    // Strobes to result and status registers
    output var  logic                    PRIMARY_DATA_UPDATE,
    output var  logic                    AUX_DATA_UPDATE,
    output var  logic                    PRIMARY_CAL_WRITE,
    output var  logic                    AUX_CAL_WRITE,
    output var  logic                    FLAG_WRITE,       // Write ready flags
    output var  logic                    READY_CLEAR       // Clear ready flags
);
    import conv_mode_pkg::*;

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic       primary_conv_enable;       // Primary enable bit
    logic       aux_conv_enable;           // Auxiliary enable bit
    conv_mode_t conv_mode_field;           // Shared mode field
    logic       next_primary_conv_enable;
    logic       next_aux_conv_enable;
    conv_mode_t next_conv_mode_field;
    logic       pending_primary;           // Single-shot work left on primary
    logic       pending_aux;               // Single-shot work left on auxiliary
    logic       next_pending_primary;
    logic       next_pending_aux;

    // Registered outputs, next values
    logic         next_p_restart, next_a_restart;
    logic         next_p_update, next_a_update;
    logic         next_p_cal, next_a_cal;
    logic         next_flag_write, next_ready_clear;

    // Decoded view of the write data
    logic       wr_primary_en;             // Primary enable in written data
    logic       wr_aux_en;
    conv_mode_t wr_mode;
    logic       single_shot;               // Mode ends by itself
    logic       mode_is_cal;               // Calibration codes 100..111
    logic       finish;                    // Last pending converter done

    // ------------------------------------------------------------
    // Mode register and sequencing, next values
    // ------------------------------------------------------------
    // The mode write takes priority over a completion in the same cycle,
    // because the write restarts the converters and the old result is stale.
    always_comb begin
        wr_primary_en            = MODE_WDATA[PRIMARY_EN_BIT];
        wr_aux_en                = MODE_WDATA[AUX_EN_BIT];
        wr_mode                  = conv_mode_t'(MODE_WDATA[MODE_MSB:MODE_LSB]);
        next_primary_conv_enable = primary_conv_enable;
        next_aux_conv_enable     = aux_conv_enable;
        next_conv_mode_field     = conv_mode_field;
        next_pending_primary     = pending_primary;
        next_pending_aux         = pending_aux;
        next_p_restart           = 1'b0;
        next_a_restart           = 1'b0;
        next_p_update            = 1'b0;
        next_a_update            = 1'b0;
        next_p_cal               = 1'b0;
        next_a_cal               = 1'b0;
        next_flag_write          = 1'b0;
        next_ready_clear         = 1'b0;
        single_shot              = (conv_mode_field == MODE_SINGLE) || conv_mode_field[2];
        mode_is_cal              = conv_mode_field[2];
        finish                   = 1'b0;
        if (MODE_WR) begin
            // New contents; every mode write restarts both converters
            next_primary_conv_enable = wr_primary_en;
            next_aux_conv_enable     = wr_aux_en;
            next_conv_mode_field     = wr_mode;
            next_p_restart           = 1'b1;
            next_a_restart           = 1'b1;
            next_pending_primary     = wr_primary_en;
            next_pending_aux         = wr_aux_en;
            next_ready_clear         = wr_mode[2];
        end else begin
            // Primary side changes restart both; auxiliary only itself
            if (PRIMARY_CTRL_WR && primary_conv_enable) begin
                next_p_restart = 1'b1;
                next_a_restart = 1'b1;
            end else if (AUX_CTRL_WR && aux_conv_enable) begin
                next_a_restart = 1'b1;
            end
            // Conversion and calibration completions
            if (primary_conv_enable && PRIMARY_DONE) begin
                if (conv_mode_field == MODE_CONTINUOUS) begin
                    next_p_update = 1'b1;
                end else if (single_shot && pending_primary) begin
                    next_p_update        = (conv_mode_field == MODE_SINGLE);
                    next_p_cal           = mode_is_cal;
                    next_pending_primary = 1'b0;
                end
            end
            if (aux_conv_enable && AUX_DONE) begin
                if (conv_mode_field == MODE_CONTINUOUS) begin
                    next_a_update = 1'b1;
                end else if (single_shot && pending_aux) begin
                    next_a_update    = (conv_mode_field == MODE_SINGLE);
                    next_a_cal       = mode_is_cal;
                    next_pending_aux = 1'b0;
                end
            end
            next_flag_write = next_p_update || next_a_update || next_p_cal || next_a_cal;
            // Single shot over once no enabled converter is still busy
            finish = single_shot && (pending_primary || pending_aux)
                     && !next_pending_primary && !next_pending_aux;
            if (finish) begin
                next_conv_mode_field = MODE_POWER_DOWN;
            end
        end
    end

    // ------------------------------------------------------------
    // Mode register and strobes, storage
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            primary_conv_enable <= 1'b0;
            aux_conv_enable     <= 1'b0;
            conv_mode_field     <= MODE_POWER_DOWN;
            pending_primary     <= 1'b0;
            pending_aux         <= 1'b0;
            PRIMARY_RESTART     <= 1'b0;
            AUX_RESTART         <= 1'b0;
            PRIMARY_DATA_UPDATE <= 1'b0;
            AUX_DATA_UPDATE     <= 1'b0;
            PRIMARY_CAL_WRITE   <= 1'b0;
            AUX_CAL_WRITE       <= 1'b0;
            FLAG_WRITE          <= 1'b0;
            READY_CLEAR         <= 1'b0;
        end else begin
            primary_conv_enable <= next_primary_conv_enable;
            aux_conv_enable     <= next_aux_conv_enable;
            conv_mode_field     <= next_conv_mode_field;
            pending_primary     <= next_pending_primary;
            pending_aux         <= next_pending_aux;
            PRIMARY_RESTART     <= next_p_restart;
            AUX_RESTART         <= next_a_restart;
            PRIMARY_DATA_UPDATE <= next_p_update;
            AUX_DATA_UPDATE     <= next_a_update;
            PRIMARY_CAL_WRITE   <= next_p_cal;
            AUX_CAL_WRITE       <= next_a_cal;
            FLAG_WRITE          <= next_flag_write;
            READY_CLEAR         <= next_ready_clear;
        end
    end

    // ------------------------------------------------------------
    // Converter controls, next values
    // ------------------------------------------------------------
    // Decoded from next-state so the outputs stay flip-flops yet
    // follow the register with no extra cycle of lag.
    logic         next_p_power, next_a_power, next_p_hold, next_a_hold;
    input_route_t next_p_route, next_a_route;
    logic         next_p_ref, next_a_ref, next_cal_active;
    logic [7:0]   next_rdata;

    // Routing for one converter in a given mode
    function automatic input_route_t route_of(input conv_mode_t m);
        unique case (m)
            MODE_INT_ZERO: route_of = ROUTE_SHORT;
            MODE_INT_FULL: route_of = ROUTE_REFERENCE;
            default:       route_of = ROUTE_CHANNEL;
        endcase
    endfunction

    always_comb begin
        next_p_power    = next_primary_conv_enable
                          && (next_conv_mode_field != MODE_POWER_DOWN);
        next_a_power    = next_aux_conv_enable
                          && (next_conv_mode_field != MODE_POWER_DOWN);
        next_p_hold     = !next_p_power || (next_conv_mode_field == MODE_IDLE);
        next_a_hold     = !next_a_power || (next_conv_mode_field == MODE_IDLE);
        next_p_route    = next_p_power ? route_of(next_conv_mode_field) : ROUTE_CHANNEL;
        next_a_route    = next_a_power ? route_of(next_conv_mode_field) : ROUTE_CHANNEL;
        next_p_ref      = PRIMARY_REF_SEL;
        next_a_ref      = AUX_REF_SEL;
        next_cal_active = next_conv_mode_field[2] && (next_p_power || next_a_power);
        next_rdata      = MODE_CTRL_RESET;
        next_rdata[PRIMARY_EN_BIT]        = next_primary_conv_enable;
        next_rdata[AUX_EN_BIT]            = next_aux_conv_enable;
        next_rdata[MODE_MSB:MODE_LSB]     = next_conv_mode_field;
    end

    // ------------------------------------------------------------
    // Converter controls, storage
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            PRIMARY_POWER      <= 1'b0;
            AUX_POWER          <= 1'b0;
            PRIMARY_HOLD_RESET <= 1'b1;
            AUX_HOLD_RESET     <= 1'b1;
            PRIMARY_CLK_EN     <= 1'b0;
            AUX_CLK_EN         <= 1'b0;
            PRIMARY_ROUTE      <= ROUTE_CHANNEL;
            AUX_ROUTE          <= ROUTE_CHANNEL;
            PRIMARY_REF_EXT    <= 1'b0;
            AUX_REF_EXT        <= 1'b0;
            CAL_ACTIVE         <= 1'b0;
            MODE_RDATA         <= MODE_CTRL_RESET;
        end else begin
            PRIMARY_POWER      <= next_p_power;
            AUX_POWER          <= next_a_power;
            PRIMARY_HOLD_RESET <= next_p_hold;
            AUX_HOLD_RESET     <= next_a_hold;
            PRIMARY_CLK_EN     <= next_p_power;
            AUX_CLK_EN         <= next_a_power;
            PRIMARY_ROUTE      <= next_p_route;
            AUX_ROUTE          <= next_a_route;
            PRIMARY_REF_EXT    <= next_p_ref;
            AUX_REF_EXT        <= next_a_ref;
            CAL_ACTIVE         <= next_cal_active;
            MODE_RDATA         <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// ==== tb/adc_mode_control_monitor.sv ====
// Assertion checker for the converter mode-control block, bound to its ports
`timescale 1ns/1ps
`default_nettype none
module adc_mode_control_monitor
    import conv_mode_pkg::*;
(
    // Clock and reset
    input wire logic                         CLK,
    input wire logic                         RESETN,
    // Register and event inputs
    input wire logic                         MODE_WR,
    input wire logic [7:0]                   MODE_WDATA,
    input wire logic                         PRIMARY_CTRL_WR,
    input wire logic                         PRIMARY_DONE,
    // Observed outputs
    input wire logic [7:0]                   MODE_RDATA,
    input wire logic                         PRIMARY_POWER,
    input wire logic                         AUX_POWER,
    input wire logic                         PRIMARY_HOLD_RESET,
    input wire logic                         PRIMARY_CLK_EN,
    input wire logic                         PRIMARY_RESTART,
    input wire logic                         AUX_RESTART,
    input wire conv_mode_pkg::input_route_t  PRIMARY_ROUTE,
    input wire logic                         PRIMARY_DATA_UPDATE,
    input wire logic                         FLAG_WRITE,
    input wire logic                         READY_CLEAR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    // ------------------------------------------------------------
    // Sequences of a one-shot finishing on the primary converter
    // ------------------------------------------------------------
    sequence prim_only_finishing;
        !MODE_WR && PRIMARY_DONE && MODE_RDATA[5:4] == 2'b10 && MODE_RDATA[2:0] inside {2, [4:7]};
    endsequence
    sequence back_to_down;
        MODE_RDATA == 8'h20 && !PRIMARY_POWER && FLAG_WRITE;
    endsequence
    AST_MODE_WRITE_RESTART: assert property (MODE_WR |=> PRIMARY_RESTART && AUX_RESTART)
        else $error("mode write did not restart both converters");
    AST_READBACK: assert property (MODE_WR |=> MODE_RDATA == ($past(MODE_WDATA) & 8'h37))
        else $error("mode register readback wrong");
    AST_PRIMARY_POWER: assert property (MODE_WR |=> PRIMARY_POWER ==
        ($past(MODE_WDATA[5]) && $past(MODE_WDATA[2:0]) != 3'h0)) else $error("primary power wrong");
    AST_AUX_POWER: assert property (MODE_WR |=> AUX_POWER ==
        ($past(MODE_WDATA[4]) && $past(MODE_WDATA[2:0]) != 3'h0)) else $error("aux power wrong");
    AST_DOWN_CODE: assert property (MODE_RDATA[2:0] == 3'h0 |-> !PRIMARY_POWER && !AUX_POWER)
        else $error("converter powered in power-down code");
    AST_IDLE_HOLD: assert property (PRIMARY_POWER && MODE_RDATA[2:0] == 3'h1
        |-> PRIMARY_HOLD_RESET && PRIMARY_CLK_EN) else $error("idle hold or clock wrong");
    AST_SHORT_ROUTE: assert property (MODE_WR && MODE_WDATA[5] && MODE_WDATA[2:0] == 3'h4
        |=> PRIMARY_ROUTE == ROUTE_SHORT) else $error("zero calibration short missing");
    AST_CAL_CLEAR: assert property (MODE_WR && MODE_WDATA[2] && MODE_WDATA[5]
        |=> READY_CLEAR) else $error("ready clear missing on calibration write");
    AST_CTRL_RESTART: assert property (PRIMARY_CTRL_WR && MODE_RDATA[5] && !MODE_WR
        |=> PRIMARY_RESTART && AUX_RESTART) else $error("control write restart missing");
    AST_CONT_UPDATE: assert property (!MODE_WR && PRIMARY_DONE && PRIMARY_POWER &&
        MODE_RDATA[2:0] == 3'h3 |=> PRIMARY_DATA_UPDATE) else $error("continuous update missing");
    AST_ONESHOT_END: assert property (prim_only_finishing |=> back_to_down)
        else $error("one-shot did not return to power-down");
endmodule
bind adc_mode_control adc_mode_control_monitor MON (.CLK(CLK), .RESETN(RESETN),
    .MODE_WR(MODE_WR), .MODE_WDATA(MODE_WDATA), .PRIMARY_CTRL_WR(PRIMARY_CTRL_WR),
    .PRIMARY_DONE(PRIMARY_DONE), .MODE_RDATA(MODE_RDATA), .PRIMARY_POWER(PRIMARY_POWER),
    .AUX_POWER(AUX_POWER), .PRIMARY_HOLD_RESET(PRIMARY_HOLD_RESET),
    .PRIMARY_CLK_EN(PRIMARY_CLK_EN), .PRIMARY_RESTART(PRIMARY_RESTART),
    .AUX_RESTART(AUX_RESTART), .PRIMARY_ROUTE(PRIMARY_ROUTE),
    .PRIMARY_DATA_UPDATE(PRIMARY_DATA_UPDATE), .FLAG_WRITE(FLAG_WRITE),
    .READY_CLEAR(READY_CLEAR));
`default_nettype wire

// ==== tb/adc_mode_control_tb.sv ====
// Self-checking testbench for the converter mode-control block
`timescale 1ns/1ps
`default_nettype none
module adc_mode_control_tb;
    import conv_mode_pkg::*;
    logic         clk, resetn, mode_wr, ref_p, ref_a;   // Driven inputs
    logic [7:0]   wdata, rdata;                         // Register port
    logic [3:0]   ev;                                   // Aux ctrl, primary ctrl, aux done, done
    logic         p_pow, a_pow, p_hold, a_hold, p_clken, a_clken, p_rst, a_rst;
    logic         p_rext, a_rext, cal_act, p_upd, a_upd, p_cal, a_cal, flag_wr, rdy_clr;
    input_route_t p_route, a_route;                     // Input routing
    int           fail_count, n_tests, cyc;             // Counters
    adc_mode_control DUT (.CLK(clk), .RESETN(resetn), .MODE_WR(mode_wr), .MODE_WDATA(wdata),
        .MODE_RDATA(rdata), .PRIMARY_CTRL_WR(ev[2]), .AUX_CTRL_WR(ev[3]),
        .PRIMARY_REF_SEL(ref_p), .AUX_REF_SEL(ref_a), .PRIMARY_DONE(ev[0]), .AUX_DONE(ev[1]),
        .PRIMARY_POWER(p_pow), .AUX_POWER(a_pow), .PRIMARY_HOLD_RESET(p_hold),
        .AUX_HOLD_RESET(a_hold), .PRIMARY_CLK_EN(p_clken), .AUX_CLK_EN(a_clken),
        .PRIMARY_RESTART(p_rst), .AUX_RESTART(a_rst), .PRIMARY_ROUTE(p_route),
        .AUX_ROUTE(a_route), .PRIMARY_REF_EXT(p_rext), .AUX_REF_EXT(a_rext),
        .CAL_ACTIVE(cal_act), .PRIMARY_DATA_UPDATE(p_upd), .AUX_DATA_UPDATE(a_upd),
        .PRIMARY_CAL_WRITE(p_cal), .AUX_CAL_WRITE(a_cal), .FLAG_WRITE(flag_wr),
        .READY_CLEAR(rdy_clr));
    // 40 MHz clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard: the whole run needs well under a few hundred cycles
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            fail_count++;
            summarize();
        end
    end
    // Compare one value and count it; wide enough for a strobe group plus readback
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    // One write strobe; outputs are looked at 1 ns after the edge that takes it
    task automatic wr(input logic [7:0] d);
        @(posedge clk) begin mode_wr <= 1'b1; wdata <= d; end
        @(posedge clk) mode_wr <= 1'b0;
        #1;
    endtask
    // One-cycle event pulse, sampled when its answer stands
    task automatic pulse(input logic [3:0] e);
        @(posedge clk) ev <= e;
        @(posedge clk) ev <= 4'h0;
        #1;
    endtask
    // Every mode code with only the primary converter enabled
    task automatic t_modes;
        for (int c = 0; c < 8; c++) begin
            wr(8'h20 | 8'(c));
            chk(rdata, 8'h20 | 8'(c));
            chk(p_rst & a_rst, 1);
            chk(p_pow, c != 0);
            chk(p_hold, c < 2);
            chk(p_clken, c != 0);
            chk(p_route, c == 4 ? 1 : (c == 5 ? 2 : 0));
            chk(p_rext, 1);
            chk(rdy_clr, c > 3);
            chk(a_pow, 0);
        end
    endtask
    // Aux alone: primary down, aux restart and continuous updates
    task automatic t_aux;
        @(posedge clk) ref_p <= 1'b0;
        wr(8'h13);
        chk({p_pow, p_hold, a_pow, a_hold, a_clken, p_rext}, 6'b011010);
        pulse(4'h8);
        chk({p_rst, a_rst}, 2'b01);
        repeat (2) begin
            pulse(4'h2);
            chk({a_upd, rdata}, {1'b1, 8'h13});
        end
    endtask
    // Primary continuous, control write, then single shot
    task automatic t_primary;
        wr(8'h23);
        pulse(4'h4);
        chk({p_rst, a_rst}, 2'b11);
        pulse(4'h1);
        chk({p_upd, rdata}, {1'b1, 8'h23});
        wr(8'h22);
        pulse(4'h1);
        chk({p_upd, flag_wr, p_pow, rdata}, {3'b110, 8'h20});
        pulse(4'h1);
        chk(p_upd, 0);
    endtask
    // Full-scale calibration of both converters
    task automatic t_cal;
        wr(8'h35);
        chk({rdy_clr, cal_act, a_rext, a_route}, {3'b111, 2'h2});
        pulse(4'h1);
        chk({p_cal, rdata}, {1'b1, 8'h35});
        pulse(4'h2);
        chk({a_cal, flag_wr, cal_act, rdata}, {3'b110, 8'h30});
    endtask
    // Counts and verdict, then stop
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        {resetn, mode_wr, ref_p, ref_a, wdata, ev} = '0;
        {fail_count, n_tests, cyc} = '0;
        repeat (20) @(posedge clk);
        resetn <= 1'b1;
        ref_p <= 1'b1;
        ref_a <= 1'b1;
        #1;
        chk({rdata, p_hold, p_pow}, {8'h00, 2'b10});
        t_modes();
        t_aux();
        t_primary();
        t_cal();
        summarize();
    end
endmodule
`default_nettype wire
